// >>> dur_params.svh
// Constants of the converter update and reset control block
`ifndef DUR_PARAMS_SVH
`define DUR_PARAMS_SVH
`define DUR_CLK_MHZ 100
`define DUR_RST_PULSE_CYC 16
`define DUR_INIT_US 4800
`define DUR_INIT_CYC (`DUR_INIT_US * `DUR_CLK_MHZ)
`define DUR_SETUP_MS 200
`define DUR_SETUP_CYC (`DUR_SETUP_MS * 1000 * `DUR_CLK_MHZ)
`define DUR_NCH 32
`define DUR_MEM_AW 11
`define DUR_MEM_DW 24
`define DUR_REG_CTRL 8'h00
`define DUR_REG_UPDCH 8'h04
`define DUR_REG_LIST 8'h08
`define DUR_REG_DIRECT 8'h0c
`define DUR_REG_SAMPLE 8'h10
`define DUR_REG_PACE 8'h14
`define DUR_REG_STATUS 8'h18
`define DUR_REG_CHSEL 8'h1c
`define DUR_REG_DACRD 8'h20
`define DUR_CTRL_RUN 0
`define DUR_CTRL_MODE 1
`define DUR_CTRL_FMT 3
`define DUR_CTRL_FLUSH 4
`define DUR_UPD_EN 8
`define DUR_LIST_SZ 8
`define DUR_STAT_BUSY 0
`define DUR_STAT_FULL 1
`define DUR_STAT_EMPTY 2
`define DUR_STAT_CNT 8
`define DUR_CODE_RST 16'h0000
`define DUR_CODE_DEF 16'h8000
`define DUR_PACE_RST 16'h0064
`endif

// >>> dur_pkg.sv
// Types shared by the converter update and reset control block
package dur_pkg;
  typedef enum logic [1:0] {
    DUR_M_SINGLE,
    DUR_M_EVENT,
    DUR_M_REGEN
  } dur_mode_e;
  typedef enum logic [1:0] {DUR_S_HOLD, DUR_S_INIT, DUR_S_DONE} dur_seq_e;
  typedef enum logic [1:0] {DUR_T_INIT, DUR_T_LOAD, DUR_T_RUN} dur_top_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } dur_av_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } dur_av_rsp_s;
  typedef struct packed {
    logic updall;
    logic hold;
    logic [5:0] ch;
    logic [15:0] code;
  } dur_smp_s;
endpackage

// >>> dur_smp_mem.sv
// Sample memory with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "dur_params.svh"
module dur_smp_mem #(
  parameter int AW = `DUR_MEM_AW,
  parameter int DW = `DUR_MEM_DW
) (
  // Clock
  input wire logic sys_clk,
  // Write side
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;
  // Read is old data on a same-address write; the control does that only when pushing into an empty memory, and never uses that read
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> dur_rst_seq.sv
// Reset sequencer: merges reset origins and times the converter start
`timescale 1ns/1ps
`default_nettype none
`include "dur_params.svh"
module dur_rst_seq #(
  parameter int INIT_CYC = `DUR_INIT_CYC
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Further reset origins
  input wire logic host_rst_req,
  input wire logic test_rst_req,
  // Derived resets and status
  output logic cpu_rst_n,
  output logic dac_rst_n,
  output logic init_busy,
  output logic seq_ready
);
  import dur_pkg::*;
  typedef struct packed {
    dur_seq_e st;
    logic [31:0] cnt;
    logic cpu_n;
    logic dac_n;
    logic busy;
    logic rdy;
  } dur_rseq_s;
  dur_rseq_s s_q;
  dur_rseq_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.rdy = 1'b0;
    case (s_q.st)
      DUR_S_HOLD: begin
        if (s_q.cnt == 32'(`DUR_RST_PULSE_CYC - 1)) begin
          s_d.st = DUR_S_INIT;
          s_d.cnt = '0;
          s_d.cpu_n = 1'b1;
          s_d.dac_n = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      DUR_S_INIT: begin
        // Converters sit at the reset code while they initialise
        if (s_q.cnt == 32'(INIT_CYC - 1)) begin
          s_d.st = DUR_S_DONE;
          s_d.busy = 1'b0;
          s_d.rdy = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      DUR_S_DONE: begin
      end
      default: begin
        s_d.st = DUR_S_HOLD;
      end
    endcase
    // Same sequence whatever the origin
    if (host_rst_req || test_rst_req) begin
      s_d.st = DUR_S_HOLD;
      s_d.cnt = '0;
      s_d.cpu_n = 1'b0;
      s_d.dac_n = 1'b0;
      s_d.busy = 1'b1;
      s_d.rdy = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.busy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign cpu_rst_n = s_q.cpu_n;
  assign dac_rst_n = s_q.dac_n;
  assign init_busy = s_q.busy;
  assign seq_ready = s_q.rdy;
endmodule
`default_nettype wire

// >>> dur_ctrl.sv
// Converter update and reset control: bus slave, stream, startup load
`timescale 1ns/1ps
`default_nettype none
`include "dur_params.svh"
module dur_ctrl #(
  parameter int NCH = `DUR_NCH,
  parameter int AW = `DUR_MEM_AW,
  parameter int INIT_CYC = `DUR_INIT_CYC,
  parameter int SETUP_CYC = `DUR_SETUP_CYC
) (
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Further reset origins
  input wire logic host_rst_req,
  input wire logic test_rst_req,
  // Derived resets
  output logic cpu_rst_n,
  output logic dac_rst_n,
  // Register bus
  input wire dur_pkg::dur_av_req_s av_req,
  output dur_pkg::dur_av_rsp_s av_rsp,
  // Startup store
  output logic nv_rd,
  output logic [5:0] nv_addr,
  input wire logic [15:0] nv_rdata,
  input wire logic nv_blank,
  // Converter codes
  output logic [NCH-1:0][15:0] dac_code
);
  import dur_pkg::*;

  localparam int LOAD_CYC = SETUP_CYC - INIT_CYC - `DUR_RST_PULSE_CYC;
  localparam int CW = AW + 1;

  typedef struct packed {
    dur_top_e st;
    logic run;
    dur_mode_e mode;
    logic fmt;
    logic upd_en;
    logic [5:0] updch;
    logic [5:0] start;
    logic [2:0] lsz;
    logic [15:0] pace;
    logic [15:0] pcnt;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [5:0] lidx;
    logic pend;
    logic [5:0] chsel;
    logic [5:0] nv_ch;
    logic nv_rd;
    logic [31:0] dl;
    logic [NCH-1:0][15:0] hold;
    logic [NCH-1:0][15:0] outs;
    logic av_wait;
    logic [31:0] av_rdata;
  } dur_st_s;

  dur_st_s s_q;
  dur_st_s s_d;
  logic init_busy;
  logic seq_ready;
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [23:0] mem_wd;
  logic [AW-1:0] mem_ra;
  logic [23:0] mem_rdata;

  // Stores one word; propagates per update method and flags
  function automatic dur_st_s dur_apply(dur_st_s s, dur_smp_s w);
    dur_st_s r;
    r = s;
    if (int'(w.ch) < NCH) begin
      r.hold[w.ch] = w.code;
      if (!w.hold && !w.updall && !s.upd_en) begin
        r.outs[w.ch] = w.code;
      end
    end
    if (w.updall) begin
      r.outs = r.hold;
    end else if (!w.hold && s.upd_en && w.ch == s.updch) begin
      r.outs = r.hold;
    end
    return r;
  endfunction

  // Power-of-two list length as a wrap mask
  function automatic logic [5:0] dur_lmask(logic [2:0] sz);
    logic [6:0] m;
    m = (7'h01 << sz) - 7'h01;
    if (sz > 3'd6) begin
      m = 7'h3f;
    end
    return m[5:0];
  endfunction

  dur_rst_seq #(
    .INIT_CYC(INIT_CYC)
  ) u_seq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .host_rst_req(host_rst_req),
    .test_rst_req(test_rst_req),
    .cpu_rst_n(cpu_rst_n),
    .dac_rst_n(dac_rst_n),
    .init_busy(init_busy),
    .seq_ready(seq_ready)
  );

  dur_smp_mem #(
    .AW(AW),
    .DW(`DUR_MEM_DW)
  ) u_mem (
    .sys_clk(sys_clk),
    .we(mem_we),
    .waddr(mem_wa),
    .wdata(mem_wd),
    .raddr(mem_ra),
    .rdata(mem_rdata)
  );

  always_comb begin
    logic push;
    logic pop;
    logic flush;
    logic ok;
    logic full;
    logic buffered;
    logic [31:0] rd;
    logic [31:0] wd;
    dur_smp_s w;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    ok = 1'b1;
    rd = '0;
    wd = av_req.writedata;
    w = '0;
    full = (s_q.cnt == CW'(1 << AW));
    buffered = (s_q.mode == DUR_M_EVENT) || (s_q.mode == DUR_M_REGEN);
    s_d = s_q;
    s_d.nv_rd = 1'b0;
    s_d.pend = 1'b0;
    mem_we = 1'b0;
    mem_wa = s_q.wp;
    mem_wd = '0;
    mem_ra = s_q.rp;

    case (s_q.st)
      DUR_T_INIT: begin
        s_d.outs = {NCH{`DUR_CODE_RST}};
        if (seq_ready) begin
          s_d.st = DUR_T_LOAD;
          s_d.hold = {NCH{`DUR_CODE_DEF}};
          s_d.nv_ch = '0;
          s_d.dl = 32'(LOAD_CYC);
        end
      end
      DUR_T_LOAD: begin
        // Store answers combinationally while nv_rd is high
        if (s_q.nv_rd) begin
          if (int'(s_q.nv_ch) < NCH) begin
            s_d.hold[s_q.nv_ch] = nv_blank ? `DUR_CODE_DEF : nv_rdata;
          end
          s_d.nv_ch = s_q.nv_ch + 6'h1;
        end else begin
          s_d.nv_rd = 1'b1;
        end
        s_d.dl = s_q.dl - 32'h1;
        // Deadline leaves unread channels at the factory code
        if ((s_q.nv_rd && int'(s_q.nv_ch) == NCH - 1) ||
            s_q.dl == '0) begin
          s_d.nv_rd = 1'b0;
          s_d.outs = s_d.hold;
          s_d.st = DUR_T_RUN;
        end
      end
      DUR_T_RUN: begin
        if (s_q.pend) begin
          w = dur_smp_s'(mem_rdata);
          if (s_q.fmt) begin
            // Channel comes from the list, not from the word
            w.ch = s_q.start + s_q.lidx;
            w.hold = 1'b0;
            w.updall = 1'b0;
            s_d.lidx = (s_q.lidx + 6'h1) & dur_lmask(s_q.lsz);
          end
          s_d = dur_apply(s_d, w);
        end
        if (s_q.run && buffered) begin
          if (s_q.pcnt == '0) begin
            s_d.pcnt = s_q.pace;
            if (s_q.cnt != '0) begin
              s_d.pend = 1'b1;
              if (s_q.mode == DUR_M_REGEN) begin
                // Replay without consuming
                if ({1'b0, s_q.rp} + CW'(1) == s_q.cnt) begin
                  s_d.rp = '0;
                end else begin
                  s_d.rp = s_q.rp + AW'(1);
                end
              end else begin
                s_d.rp = s_q.rp + AW'(1);
                pop = 1'b1;
              end
            end
          end else begin
            s_d.pcnt = s_q.pcnt - 16'h1;
          end
        end
      end
      default: begin
        s_d.st = DUR_T_INIT;
      end
    endcase

    // Register bus: one wait cycle, then a one-cycle answer
    if (!s_q.av_wait) begin
      s_d.av_wait = 1'b1;
    end else if (av_req.read || av_req.write) begin
      if (av_req.read) begin
        case (av_req.address)
          `DUR_REG_CTRL: begin
            rd[`DUR_CTRL_RUN] = s_q.run;
            rd[`DUR_CTRL_MODE +: 2] = s_q.mode;
            rd[`DUR_CTRL_FMT] = s_q.fmt;
          end
          `DUR_REG_UPDCH: begin
            rd[5:0] = s_q.updch;
            rd[`DUR_UPD_EN] = s_q.upd_en;
          end
          `DUR_REG_LIST: begin
            rd[5:0] = s_q.start;
            rd[`DUR_LIST_SZ +: 3] = s_q.lsz;
          end
          `DUR_REG_PACE: rd[15:0] = s_q.pace;
          `DUR_REG_STATUS: begin
            rd[`DUR_STAT_BUSY] = (s_q.st != DUR_T_RUN) || init_busy;
            rd[`DUR_STAT_FULL] = full;
            rd[`DUR_STAT_EMPTY] = (s_q.cnt == '0);
            rd[`DUR_STAT_CNT +: CW] = s_q.cnt;
          end
          `DUR_REG_CHSEL: rd[5:0] = s_q.chsel;
          `DUR_REG_DACRD: begin
            if (int'(s_q.chsel) < NCH) begin
              rd[15:0] = s_q.outs[s_q.chsel];
            end
          end
          default: rd = '0;
        endcase
      end else if (av_req.byteenable == 4'hf) begin
        case (av_req.address)
          `DUR_REG_CTRL: begin
            s_d.run = wd[`DUR_CTRL_RUN];
            s_d.mode = dur_mode_e'(wd[`DUR_CTRL_MODE +: 2]);
            s_d.fmt = wd[`DUR_CTRL_FMT];
            flush = wd[`DUR_CTRL_FLUSH];
          end
          `DUR_REG_UPDCH: begin
            s_d.updch = wd[5:0];
            s_d.upd_en = wd[`DUR_UPD_EN];
          end
          `DUR_REG_LIST: begin
            s_d.start = wd[5:0];
            s_d.lsz = wd[`DUR_LIST_SZ +: 3];
            s_d.lidx = '0;
          end
          `DUR_REG_PACE: s_d.pace = wd[15:0];
          `DUR_REG_CHSEL: s_d.chsel = wd[5:0];
          `DUR_REG_DIRECT: begin
            // Accepted in every mode once running
            if (s_q.st == DUR_T_RUN) begin
              s_d = dur_apply(s_d, dur_smp_s'(wd[23:0]));
            end
          end
          `DUR_REG_SAMPLE: begin
            // Full memory stalls the bus instead of losing data
            if (buffered && s_q.st == DUR_T_RUN) begin
              if (full) begin
                ok = 1'b0;
              end else begin
                push = 1'b1;
                mem_we = 1'b1;
                mem_wd = wd[23:0];
                s_d.wp = s_q.wp + AW'(1);
              end
            end
          end
          default: ok = 1'b1;
        endcase
      end
      if (ok) begin
        s_d.av_wait = 1'b0;
        s_d.av_rdata = rd;
      end
    end

    if (flush) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
      s_d.lidx = '0;
      s_d.pend = 1'b0;
    end else begin
      s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
    end
  end

  // Origins act at once, so codes drop with the resets
  always_ff @(posedge sys_clk) begin
    if (!rstn || !dac_rst_n ||
        host_rst_req || test_rst_req) begin
      s_q <= '0;
      s_q.outs <= {NCH{`DUR_CODE_RST}};
      s_q.pace <= `DUR_PACE_RST;
      s_q.av_wait <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign av_rsp.readdata = s_q.av_rdata;
  assign av_rsp.waitrequest = s_q.av_wait;
  assign nv_rd = s_q.nv_rd;
  assign nv_addr = s_q.nv_ch;
  assign dac_code = s_q.outs;
endmodule
`default_nettype wire

// >>> dur_nv_model.sv
// Startup store model answering converter code reads
`timescale 1ns/1ps
`default_nettype none
module dur_nv_model (
  // Store link
  input wire logic nv_rd,
  input wire logic [5:0] nv_addr,
  output logic [15:0] nv_rdata
);
  // Inverted outside a read, so stale data never passes for a fresh answer
  assign nv_rdata = nv_rd ? {10'h15a, nv_addr}
                          : ~{10'h15a, nv_addr};
endmodule
`default_nettype wire

// >>> dur_ctrl_props.sv
// Checker of reset sequencing and converter output rules
`timescale 1ns/1ps
`default_nettype none
module dur_ctrl_props import dur_pkg::*; #(
  parameter int NCH = 32,
  parameter int AW = 11,
  parameter int INIT_CYC = 480000,
  parameter int SETUP_CYC = 20000000
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic host_rst_req,
  input wire logic test_rst_req,
  input wire logic cpu_rst_n,
  input wire logic dac_rst_n,
  // Bus, store and codes
  input wire dur_pkg::dur_av_req_s av_req,
  input wire dur_pkg::dur_av_rsp_s av_rsp,
  input wire logic nv_rd,
  input wire logic [5:0] nv_addr,
  input wire logic [15:0] nv_rdata,
  input wire logic nv_blank,
  input wire logic [NCH-1:0][15:0] dac_code
);
  // Cycles since converter reset release, saturating
  logic [31:0] since_q;
  logic [31:0] since_d;
  always_comb begin
    since_d = since_q;
    if (!dac_rst_n) since_d = '0;
    else if (since_q < SETUP_CYC) since_d = since_q + 32'h1;
  end
  always_ff @(posedge sys_clk) since_q <= rstn ? since_d : '0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_init_quiet;
    (dac_code == '0) [*8];
  endsequence

  a_host_origin: assert property (
    host_rst_req |=> !cpu_rst_n && !dac_rst_n)
    else $error("host origin did not reset");
  a_test_origin: assert property (
    test_rst_req |=> !cpu_rst_n && !dac_rst_n)
    else $error("test origin did not reset");
  a_resets_paired: assert property (
    $rose(cpu_rst_n) |-> $rose(dac_rst_n))
    else $error("resets released apart");
  a_hold_length: assert property (
    $rose(dac_rst_n) |-> !$past(dac_rst_n, 16))
    else $error("reset hold too short");
  a_reset_code: assert property (!dac_rst_n |-> dac_code == '0)
    else $error("code not zero in reset");
  a_init_quiet: assert property (
    $rose(dac_rst_n) |-> s_init_quiet)
    else $error("code left zero during init");
  a_init_ignore: assert property (
    since_q < INIT_CYC |-> dac_code == '0)
    else $error("code moved during init");
  a_setup_deadline: assert property (
    since_q == SETUP_CYC - 16 |-> dac_code != '0)
    else $error("startup codes late");
  a_store_boot: assert property (
    nv_rd |-> cpu_rst_n && dac_rst_n ##1 !nv_rd)
    else $error("store read in reset or too close");
  a_bus_hold: assert property (!dac_rst_n |-> av_rsp.waitrequest)
    else $error("bus answered in reset");
endmodule

bind dur_ctrl dur_ctrl_props #(
  .NCH(NCH), .AW(AW), .INIT_CYC(INIT_CYC), .SETUP_CYC(SETUP_CYC)
) dur_ctrl_props_inst (
  .sys_clk, .rstn, .host_rst_req, .test_rst_req, .cpu_rst_n, .dac_rst_n,
  .av_req, .av_rsp, .nv_rd, .nv_addr, .nv_rdata, .nv_blank, .dac_code
);
`default_nettype wire

// >>> dur_ctrl_tb.sv
// Self-checking bench of the converter update and reset control
`timescale 1ns/1ps
`default_nettype none
module dur_ctrl_tb;
  import dur_pkg::*;
  localparam int NCH = 32;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic host_rst_req = 1'b0;
  logic test_rst_req = 1'b0;
  logic nv_blank = 1'b0;
  logic cpu_rst_n, dac_rst_n, nv_rd;
  logic [5:0] nv_addr;
  logic [15:0] nv_rdata;
  logic [NCH-1:0][15:0] dac_code;
  dur_av_req_s av_req = '0;
  dur_av_rsp_s av_rsp;
  logic [31:0] rd;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;

  dur_ctrl #(.NCH(NCH), .INIT_CYC(50), .SETUP_CYC(2000)) dur_ctrl_inst (
    .sys_clk, .rstn, .host_rst_req, .test_rst_req, .cpu_rst_n, .dac_rst_n,
    .av_req, .av_rsp, .nv_rd, .nv_addr, .nv_rdata, .nv_blank, .dac_code
  );
  dur_nv_model dur_nv_model_inst (.nv_rd, .nv_addr, .nv_rdata);

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard; the full run needs about nine thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    av_req <= '{read: !wr, write: wr, address: a, byteenable: 4'hf,
                writedata: d};
    do @(posedge sys_clk); while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    av_req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wait_code(input int ch, input logic [15:0] exp);
    int n;
    n = 0;
    while (dac_code[ch] !== exp && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    check(32'(dac_code[ch]), 32'(exp));
  endtask

  task automatic load_all();
    for (int i = 0; i < NCH; i++)
      wait_code(i, nv_blank ? 16'h8000 : {10'h15a, 6'(i)});
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    check(32'(dac_code[0]), 32'h0);
    load_all();
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h0c, 32'h0003_1234);
    check(32'(dac_code[3]), 32'h1234);
    bus(1'b1, 8'h1c, 32'h3);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0000_1234);
    bus(1'b1, 8'h0c, 32'h0005_5555);
    bus(1'b1, 8'h0c, 32'h0044_4321);
    check(32'(dac_code[4]), 32'h5684);
    bus(1'b1, 8'h0c, 32'h0080_0000);
    check(32'(dac_code[4]), 32'h4321);
    bus(1'b1, 8'h04, 32'h0000_0107);
    bus(1'b1, 8'h0c, 32'h0005_aaaa);
    check(32'(dac_code[5]), 32'h5555);
    bus(1'b1, 8'h0c, 32'h0007_bbbb);
    check(32'(dac_code[5]), 32'haaaa);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h10, 32'h0009_0001);
    bus(1'b0, 8'h18, 32'h0);
    check(32'(rd[19:8]), 32'h0);
    bus(1'b0, 8'h3c, 32'h0);
    check(rd, 32'h0);
    // Tagged stream, then a two-channel fixed list at 30
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h00, 32'h2);
    bus(1'b1, 8'h10, 32'h0009_0777);
    bus(1'b1, 8'h00, 32'h3);
    wait_code(9, 16'h0777);
    bus(1'b1, 8'h00, 32'ha);
    bus(1'b1, 8'h08, 32'h0000_011e);
    bus(1'b1, 8'h10, 32'h1111);
    bus(1'b1, 8'h10, 32'h2222);
    bus(1'b1, 8'h00, 32'hb);
    wait_code(30, 16'h1111);
    wait_code(31, 16'h2222);
    // Replay restores a channel overwritten by a direct write
    bus(1'b1, 8'h00, 32'h14);
    bus(1'b1, 8'h10, 32'h000a_0a0a);
    bus(1'b1, 8'h00, 32'h5);
    wait_code(10, 16'h0a0a);
    bus(1'b1, 8'h0c, 32'h000a_0000);
    bus(1'b1, 8'h0c, 32'h000c_0c0c);
    check(32'(dac_code[12]), 32'h0c0c);
    wait_code(10, 16'h0a0a);
    bus(1'b1, 8'h00, 32'h10);
    // Fill the sample memory to the brim, then empty it again
    bus(1'b1, 8'h00, 32'h2);
    for (int i = 0; i < 2048; i++) begin
      bus(1'b1, 8'h10, 32'h0);
    end
    bus(1'b0, 8'h18, 32'h0);
    check(rd, 32'h0008_0002);
    bus(1'b1, 8'h00, 32'h10);
    nv_blank <= 1'b1;
    host_rst_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    host_rst_req <= 1'b0;
    @(posedge sys_clk);
    check(32'(dac_code[3]), 32'h0);
    load_all();
    nv_blank <= 1'b0;
    test_rst_req <= 1'b1;
    @(posedge sys_clk);
    test_rst_req <= 1'b0;
    @(posedge sys_clk);
    bus(1'b1, 8'h0c, 32'h0003_1234);
    check(32'(dac_code[3]), 32'h0);
    load_all();
    repeat (2000) @(posedge sys_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
